// >>> core/cancs_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
`include "cancs_regs.svh"
module cancs_ctrl #(
    parameter int CNT_W = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic reset_mode,
    output logic tx_start,
    output logic tx_abort,
    output logic tx_no_retry,
    output logic rx_release,
    output logic tx_buf_locked,
    input wire logic tx_started,
    input wire logic tx_done_ok,
    input wire logic tx_done_err,
    input wire logic rx_active,
    input wire logic rx_fifo_nonempty,
    input wire logic rx_msg_accepted,
    input wire logic rx_fifo_full,
    input wire logic bus_off,
    input wire logic [CNT_W-1:0] tx_err_cnt,
    input wire logic [CNT_W-1:0] rx_err_cnt
);
    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    function automatic logic hit(input logic [31:0] a, input logic [7:0] idx);
        hit = (a[31:10] == 22'h0) && (a[9:2] == idx) && (a[1:0] == 2'h0);
    endfunction : hit

    logic acc, wr, rd, mapped;
    assign acc = psel && penable;
    assign wr = acc && pwrite && pstrb[0];
    assign rd = acc && !pwrite;
    assign mapped = hit(paddr, `CANCS_IDX_CONTROL) || hit(paddr, `CANCS_IDX_COMMAND)
        || hit(paddr, `CANCS_IDX_STATUS) || hit(paddr, `CANCS_IDX_INTR)
        || hit(paddr, `CANCS_IDX_ERRCNT);
    assign pready = 1'b1;
    assign pslverr = acc && !mapped;

    logic ctl_wr, cmd_wr, int_rd;
    assign ctl_wr = wr && hit(paddr, `CANCS_IDX_CONTROL);
    assign cmd_wr = wr && hit(paddr, `CANCS_IDX_COMMAND);
    assign int_rd = rd && hit(paddr, `CANCS_IDX_INTR);

    // ------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------
    logic [4:0] ctl_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_r <= `CANCS_CTL_RESET;
        end else if (ctl_wr) begin
            ctl_r <= pwdata[4:0];
        end
    end
    assign reset_mode = ctl_r[`CANCS_CTL_RESET_REQ];

    // ------------------------------------------------------------
    // Command pulses, never stored; sleep bit is ignored
    // ------------------------------------------------------------
    logic cmd_tx, cmd_abort, cmd_rel, cmd_clr;
    assign cmd_tx = cmd_wr && pwdata[`CANCS_CMD_TX_REQ] && !reset_mode;
    assign cmd_abort = cmd_wr && pwdata[`CANCS_CMD_ABORT];
    assign cmd_rel = cmd_wr && pwdata[`CANCS_CMD_RELEASE];
    assign cmd_clr = cmd_wr && pwdata[`CANCS_CMD_CLR_OVR];

    // ------------------------------------------------------------
    // Transmit sequencing
    // ------------------------------------------------------------
    cancs_pkg::cancs_tx_e tx_r;
    logic no_retry_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_r <= cancs_pkg::CANCS_TX_IDLE;
        end else if (reset_mode) begin
            tx_r <= cancs_pkg::CANCS_TX_IDLE;
        end else begin
            unique case (tx_r)
                cancs_pkg::CANCS_TX_IDLE: begin
                    if (cmd_tx) begin
                        tx_r <= cancs_pkg::CANCS_TX_PEND;
                    end
                end
                cancs_pkg::CANCS_TX_PEND: begin
                    if (cmd_abort) begin
                        tx_r <= cancs_pkg::CANCS_TX_IDLE;
                    end else if (tx_started) begin
                        tx_r <= cancs_pkg::CANCS_TX_BUSY;
                    end
                end
                cancs_pkg::CANCS_TX_BUSY: begin
                    // An abort here lets the frame run but sets no_retry_r, so a failed frame ends without retry
                    if (tx_done_ok || (tx_done_err && no_retry_r)) begin
                        tx_r <= cancs_pkg::CANCS_TX_IDLE;
                    end
                end
                default: tx_r <= cancs_pkg::CANCS_TX_IDLE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            no_retry_r <= 1'b0;
        end else if (tx_r == cancs_pkg::CANCS_TX_IDLE) begin
            no_retry_r <= 1'b0;
        end else if (cmd_abort && tx_r == cancs_pkg::CANCS_TX_BUSY) begin
            no_retry_r <= 1'b1;
        end
    end

    assign tx_start = cmd_tx && tx_r == cancs_pkg::CANCS_TX_IDLE;
    assign tx_abort = reset_mode || (cmd_abort && tx_r == cancs_pkg::CANCS_TX_PEND);
    assign tx_no_retry = no_retry_r;
    assign rx_release = cmd_rel;

    logic tx_busy;
    assign tx_busy = tx_r != cancs_pkg::CANCS_TX_IDLE;
    assign tx_buf_locked = tx_busy;

    // ------------------------------------------------------------
    // Sticky status: complete and overrun
    // ------------------------------------------------------------
    logic tcs_r, dos_r, rbs_hold_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tcs_r <= 1'b1;
        end else if (tx_r == cancs_pkg::CANCS_TX_BUSY && tx_done_ok) begin
            tcs_r <= 1'b1;
        end else if (tx_start) begin
            tcs_r <= 1'b0;
        end
    end

    logic ovr_evt;
    assign ovr_evt = rx_msg_accepted && rx_fifo_full && !reset_mode;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dos_r <= 1'b0;
        end else if (ovr_evt) begin
            dos_r <= 1'b1;
        end else if (cmd_clr) begin
            dos_r <= 1'b0;
        end
    end

    // Receive flag drops for two cycles on release (command cycle and the next) so software sees a fresh edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rbs_hold_r <= 1'b0;
        end else begin
            rbs_hold_r <= cmd_rel;
        end
    end

    logic rx_available_flag, warn;
    assign rx_available_flag = rx_fifo_nonempty && !cmd_rel && !rbs_hold_r;
    assign warn = (tx_err_cnt >= CNT_W'(`CANCS_WARN_LIMIT))
        || (rx_err_cnt >= CNT_W'(`CANCS_WARN_LIMIT));

    logic [7:0] status;
    assign status = {bus_off, warn, tx_r == cancs_pkg::CANCS_TX_BUSY, rx_active,
        tcs_r, !tx_busy, dos_r, rx_available_flag};

    // ------------------------------------------------------------
    // Interrupt flags
    // ------------------------------------------------------------
    logic [3:0] int_r;
    logic dos_q, tbs_q, err_q, bus_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dos_q <= 1'b0;
            tbs_q <= 1'b1;
            err_q <= 1'b0;
            bus_q <= 1'b0;
        end else begin
            dos_q <= dos_r;
            tbs_q <= !tx_busy;
            err_q <= warn;
            bus_q <= bus_off;
        end
    end

    logic [3:0] int_set;
    assign int_set[`CANCS_INT_RX] = ctl_r[`CANCS_CTL_RX_IE] && rx_available_flag;
    assign int_set[`CANCS_INT_TX] = ctl_r[`CANCS_CTL_TX_IE] && !tx_busy && !tbs_q;
    assign int_set[`CANCS_INT_ERR] = ctl_r[`CANCS_CTL_ERR_IE]
        && ((warn != err_q) || (bus_off != bus_q));
    assign int_set[`CANCS_INT_OVR] = ctl_r[`CANCS_CTL_OVR_IE] && dos_r && !dos_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_r <= 4'h0;
        end else begin
            int_r[`CANCS_INT_RX] <= int_set[`CANCS_INT_RX]
                || (int_r[`CANCS_INT_RX] && !cmd_rel);
            for (int i = `CANCS_INT_TX; i <= `CANCS_INT_OVR; i++) begin
                int_r[i] <= int_set[i] || (int_r[i] && !int_rd);
            end
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (psel && !penable && !pwrite) begin
            if (hit(paddr, `CANCS_IDX_CONTROL)) begin
                prdata <= {24'h0, `CANCS_CTL_RSVD, ctl_r};
            end else if (hit(paddr, `CANCS_IDX_STATUS)) begin
                prdata <= {24'h0, status};
            end else if (hit(paddr, `CANCS_IDX_INTR)) begin
                prdata <= {24'h0, `CANCS_INT_RSVD, int_r};
            end else if (hit(paddr, `CANCS_IDX_ERRCNT)) begin
                prdata <= {16'h0, 8'(rx_err_cnt), 8'(tx_err_cnt)};
            end else begin
                prdata <= 32'h0;
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_ctl_reset;
        @(posedge pclk) $rose(presetn) |-> ctl_r == `CANCS_CTL_RESET;
    endproperty
    a_ctl_reset: assert property (p_ctl_reset) else $error("control reset wrong");

    property p_rr_abort;
        @(posedge pclk) disable iff (!presetn) reset_mode |=> tx_r == cancs_pkg::CANCS_TX_IDLE;
    endproperty
    a_rr_abort: assert property (p_rr_abort) else $error("reset mode kept transfer");

    property p_tx_req;
        @(posedge pclk) disable iff (!presetn)
            tx_start |=> tx_r == cancs_pkg::CANCS_TX_PEND && !tcs_r;
    endproperty
    a_tx_req: assert property (p_tx_req) else $error("request not taken");

    property p_abort_busy;
        @(posedge pclk) disable iff (!presetn)
            tx_r == cancs_pkg::CANCS_TX_BUSY && cmd_abort && !reset_mode && !tx_done_ok
            && !tx_done_err |=> tx_r == cancs_pkg::CANCS_TX_BUSY && no_retry_r;
    endproperty
    a_abort_busy: assert property (p_abort_busy) else $error("started frame aborted");

    property p_ovr_clear;
        @(posedge pclk) disable iff (!presetn) dos_r && !cmd_clr |=> dos_r;
    endproperty
    a_ovr_clear: assert property (p_ovr_clear) else $error("overrun cleared");

    property p_tbs;
        @(posedge pclk) disable iff (!presetn) status[5] |-> !status[2];
    endproperty
    a_tbs: assert property (p_tbs) else $error("buffer free while sending");

    property p_warn;
        @(posedge pclk) disable iff (!presetn)
            status[6] == (tx_err_cnt >= CNT_W'(`CANCS_WARN_LIMIT)
            || rx_err_cnt >= CNT_W'(`CANCS_WARN_LIMIT));
    endproperty
    a_warn: assert property (p_warn) else $error("warning bit wrong");

    property p_int_en;
        @(posedge pclk) disable iff (!presetn)
            !ctl_r[`CANCS_CTL_OVR_IE] && !int_r[`CANCS_INT_OVR] |=> !int_r[`CANCS_INT_OVR];
    endproperty
    a_int_en: assert property (p_int_en) else $error("disabled flag set");

    property p_rel;
        @(posedge pclk) disable iff (!presetn) cmd_rel |=> !status[0];
    endproperty
    a_rel: assert property (p_rel) else $error("receive flag held on release");

    property p_abort_pend;
        @(posedge pclk) disable iff (!presetn)
            tx_r == cancs_pkg::CANCS_TX_PEND && cmd_abort && !reset_mode
            |=> tx_r == cancs_pkg::CANCS_TX_IDLE && !tx_buf_locked;
    endproperty
    a_abort_pend: assert property (p_abort_pend) else $error("pending frame kept");

    property p_no_retry_end;
        @(posedge pclk) disable iff (!presetn)
            tx_r == cancs_pkg::CANCS_TX_BUSY && tx_done_err && no_retry_r && !reset_mode
            |=> tx_r == cancs_pkg::CANCS_TX_IDLE;
    endproperty
    a_no_retry_end: assert property (p_no_retry_end) else $error("aborted frame retried");

    property p_tcs_set;
        @(posedge pclk) disable iff (!presetn)
            tx_r == cancs_pkg::CANCS_TX_BUSY && tx_done_ok |=> status[3];
    endproperty
    a_tcs_set: assert property (p_tcs_set) else $error("complete not set");

    property p_tcs_hold;
        @(posedge pclk) disable iff (!presetn)
            !status[3] && !(tx_r == cancs_pkg::CANCS_TX_BUSY && tx_done_ok) |=> !status[3];
    endproperty
    a_tcs_hold: assert property (p_tcs_hold) else $error("complete set without success");

    property p_ovr_set;
        @(posedge pclk) disable iff (!presetn) ovr_evt |=> status[1];
    endproperty
    a_ovr_set: assert property (p_ovr_set) else $error("overrun not flagged");

    property p_rx_int_clr;
        @(posedge pclk) disable iff (!presetn) cmd_rel |=> !int_r[`CANCS_INT_RX];
    endproperty
    a_rx_int_clr: assert property (p_rx_int_clr) else $error("receive flag kept");

    property p_sts_ro;
        @(posedge pclk) disable iff (!presetn)
            wr && hit(paddr, `CANCS_IDX_STATUS) |=> $stable(ctl_r);
    endproperty
    a_sts_ro: assert property (p_sts_ro) else $error("status write had effect");

    property p_cmd_pulse;
        @(posedge pclk) disable iff (!presetn) rx_release |=> !rx_release;
    endproperty
    a_cmd_pulse: assert property (p_cmd_pulse) else $error("command held");

    property p_rx_int_en;
        @(posedge pclk) disable iff (!presetn)
            !ctl_r[`CANCS_CTL_RX_IE] && !int_r[`CANCS_INT_RX] |=> !int_r[`CANCS_INT_RX];
    endproperty
    a_rx_int_en: assert property (p_rx_int_en) else $error("disabled receive flag set");

    c_tx_ok: cover property (@(posedge pclk) disable iff (!presetn)
        tx_r == cancs_pkg::CANCS_TX_BUSY ##1 tcs_r);
    c_abort: cover property (@(posedge pclk) disable iff (!presetn)
        tx_r == cancs_pkg::CANCS_TX_PEND && cmd_abort);
    c_ovr: cover property (@(posedge pclk) disable iff (!presetn) ovr_evt);
    c_rst_abort: cover property (@(posedge pclk) disable iff (!presetn)
        reset_mode && tx_r == cancs_pkg::CANCS_TX_PEND);
    c_rel: cover property (@(posedge pclk) disable iff (!presetn)
        cmd_rel ##2 status[0]);
endmodule : cancs_ctrl
`default_nettype wire

// >>> core/cancs_regs.svh
`ifndef CANCS_REGS_SVH
`define CANCS_REGS_SVH
// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define CANCS_IDX_CONTROL 8'h00
`define CANCS_IDX_COMMAND 8'h01
`define CANCS_IDX_STATUS 8'h02
`define CANCS_IDX_INTR 8'h03
`define CANCS_IDX_ERRCNT 8'h04
// ----------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------
`define CANCS_CTL_RESET_REQ 0
`define CANCS_CTL_RX_IE 1
`define CANCS_CTL_TX_IE 2
`define CANCS_CTL_ERR_IE 3
`define CANCS_CTL_OVR_IE 4
`define CANCS_CTL_RESET 5'h01
`define CANCS_CTL_RSVD 3'h1
// ----------------------------------------------------------------
// Command fields
// ----------------------------------------------------------------
`define CANCS_CMD_TX_REQ 0
`define CANCS_CMD_ABORT 1
`define CANCS_CMD_RELEASE 2
`define CANCS_CMD_CLR_OVR 3
`define CANCS_CMD_SLEEP 4
// ----------------------------------------------------------------
// Interrupt register fields
// ----------------------------------------------------------------
`define CANCS_INT_RX 0
`define CANCS_INT_TX 1
`define CANCS_INT_ERR 2
`define CANCS_INT_OVR 3
`define CANCS_INT_RSVD 4'hE
// ----------------------------------------------------------------
// Limits
// ----------------------------------------------------------------
`define CANCS_WARN_LIMIT 8'h60
`endif

// >>> core/cancs_pkg.sv
package cancs_pkg;
    typedef enum logic [1:0] {
        CANCS_TX_IDLE = 2'b00,
        CANCS_TX_PEND = 2'b01,
        CANCS_TX_BUSY = 2'b10
    } cancs_tx_e;
endpackage : cancs_pkg

// >>> verif/cancs_core_model.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------
// Network side: transmit engine and receive FIFO
// ----------------------------------------------------------------
module cancs_core_model #(
    parameter int DEPTH = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic tx_start,
    input wire logic tx_abort,
    input wire logic rx_release,
    input wire logic rx_push,
    input wire logic tx_fail,
    input wire logic [7:0] start_dly,
    output logic tx_started,
    output logic tx_done_ok,
    output logic tx_done_err,
    output logic rx_msg_accepted,
    output logic rx_fifo_nonempty,
    output logic rx_fifo_full
);
    int cnt;
    int nm;
    logic pend;
    logic busy;
    // A long start delay leaves room for an abort before the frame begins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 0;
            pend <= 1'h0;
            busy <= 1'h0;
            tx_started <= 1'h0;
            tx_done_ok <= 1'h0;
            tx_done_err <= 1'h0;
        end else begin
            tx_started <= 1'h0;
            tx_done_ok <= 1'h0;
            tx_done_err <= 1'h0;
            if (tx_start) begin
                pend <= 1'h1;
                cnt <= int'(start_dly);
            end else if ((pend || busy) && tx_abort) begin
                pend <= 1'h0;
                busy <= 1'h0;
            end else if (pend && cnt == 0) begin
                pend <= 1'h0;
                busy <= 1'h1;
                cnt <= 10;
                tx_started <= 1'h1;
            end else if (busy && cnt == 0) begin
                busy <= 1'h0;
                tx_done_ok <= !tx_fail;
                tx_done_err <= tx_fail;
            end else if (cnt > 0) begin
                cnt <= cnt - 1;
            end
        end
    end
    // A message offered to a full FIFO is dropped here
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            nm <= 0;
        end else begin
            nm <= nm + int'(rx_push && nm < DEPTH) - int'(rx_release && nm > 0);
        end
    end
    assign rx_msg_accepted = rx_push;
    assign rx_fifo_nonempty = nm > 0;
    assign rx_fifo_full = nm == DEPTH;
endmodule : cancs_core_model
`default_nettype wire

// >>> verif/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rdv, v;
    logic [3:0] pstrb = 4'hF;
    logic pready, pslverr, reset_mode, tx_start, tx_abort, tx_no_retry, rx_release, tx_buf_locked;
    logic tx_started, tx_done_ok, tx_done_err, rx_msg_accepted, rx_fifo_nonempty, rx_fifo_full;
    logic rx_push = 1'h0, tx_fail = 1'h0, bus_off = 1'h0, rx_active = 1'h0, sev;
    logic [7:0] sdly = 8'h28, tx_err_cnt = 8'h0, rx_err_cnt = 8'h0;
    logic ts = 1'h0, tx_complete_flag = 1'h1, tx_buffer_free_flag = 1'h1, overrun_flag = 1'h0;
    int nm = 0, err_count = 0, check_count = 0, cyc = 0, i;
    localparam int IDX_CTL = 0, IDX_CMD = 1, IDX_STS = 2, IDX_INT = 3, IDX_ERR = 4, IDX_NONE = 5;
    cancs_ctrl #(.CNT_W(8)) uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pstrb, .prdata, .pready, .pslverr, .reset_mode, .tx_start, .tx_abort, .tx_no_retry,
        .rx_release, .tx_buf_locked, .tx_started, .tx_done_ok, .tx_done_err, .rx_active,
        .rx_fifo_nonempty, .rx_msg_accepted, .rx_fifo_full, .bus_off, .tx_err_cnt, .rx_err_cnt);
    cancs_core_model #(.DEPTH(4)) u_core (.pclk, .presetn, .tx_start, .tx_abort, .rx_release,
        .rx_push, .tx_fail, .start_dly(sdly), .tx_started, .tx_done_ok, .tx_done_err,
        .rx_msg_accepted, .rx_fifo_nonempty, .rx_fifo_full);
    // ----------------------------------------------------------------
    // Bus tasks and reference model
    // ----------------------------------------------------------------
    task automatic stop_test();
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : stop_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t %s got %0h exp %0h", $time, m, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'h1);
        rdv = prdata;
        sev = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb
    task automatic wr(input int x, input logic [31:0] d);
        apb(1'h1, 32'(4 * x), d);
    endtask : wr
    task automatic rd(input int x);
        apb(1'h0, 32'(4 * x), 32'h0);
    endtask : rd
    function automatic logic [7:0] exp_st();
        logic es;
        es = (int'(tx_err_cnt) >= 96) || (int'(rx_err_cnt) >= 96);
        return {bus_off, es, ts, rx_active, tx_complete_flag, tx_buffer_free_flag, overrun_flag, nm > 0};
    endfunction : exp_st
    task automatic chk_st();
        rd(IDX_STS);
        chk(rdv, {24'h0, exp_st()}, "status");
        chk({31'h0, tx_buf_locked}, {31'h0, !tx_buffer_free_flag}, "buffer lock");
    endtask : chk_st
    // Bounded wait; a missing event counts as a mismatch
    task automatic wt(ref logic s);
        int n;
        n = 0;
        while (s !== 1'h1 && n < 200) begin
            @(posedge pclk);
            n++;
        end
        chk({31'h0, s}, 32'h1, "event");
    endtask : wt
    task automatic push();
        @(posedge pclk);
        rx_push <= 1'h1;
        @(posedge pclk);
        rx_push <= 1'h0;
        if (nm < 4) nm++;
        else overrun_flag = 1'h1;
    endtask : push
    // Extra cycle: receive status is held low just after a release
    task automatic rel();
        wr(IDX_CMD, 32'h4);
        if (nm > 0) nm--;
        @(posedge pclk);
    endtask : rel
    initial begin
        forever #50 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc++;
        if (cyc > 5000) begin
            err_count++;
            stop_test();
        end
    end
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    initial begin
        i = $urandom(26794);
        repeat (4) @(posedge pclk);
        presetn <= 1'h1;
        rd(IDX_CTL);
        chk(rdv, 32'h21, "control reset");
        chk_st();
        rd(IDX_NONE);
        chk({rdv[30:0], sev}, 32'h1, "unmapped");
        chk({31'h0, pready}, 32'h1, "ready");
        for (i = 0; i < 6; i++) begin
            v = $urandom;
            wr(IDX_CTL, v);
            rd(IDX_CTL);
            chk(rdv, {24'h0, 3'h1, v[4:0]}, "control");
        end
        wr(IDX_STS, 32'hFF);
        chk_st();
        wr(IDX_CTL, 32'h4);
        wr(IDX_CMD, 32'h0);
        chk_st();
        wr(IDX_CMD, 32'h1);
        tx_complete_flag = 1'h0;
        tx_buffer_free_flag = 1'h0;
        chk_st();
        wt(tx_started);
        ts = 1'h1;
        chk_st();
        wt(tx_done_ok);
        ts = 1'h0;
        tx_complete_flag = 1'h1;
        tx_buffer_free_flag = 1'h1;
        chk_st();
        rd(IDX_INT);
        chk(rdv, 32'hE2, "tx irq");
        rd(IDX_INT);
        chk(rdv, 32'hE0, "irq cleared");
        wr(IDX_CTL, 32'h0);
        wr(IDX_CMD, 32'h1);
        wr(IDX_CMD, 32'h2);
        tx_complete_flag = 1'h0;
        chk_st();
        tx_fail <= 1'h1;
        wr(IDX_CMD, 32'h1);
        wt(tx_started);
        wr(IDX_CMD, 32'h2);
        @(posedge pclk);
        chk({31'h0, tx_no_retry}, 32'h1, "no retry");
        wt(tx_done_err);
        chk_st();
        rd(IDX_INT);
        chk(rdv, 32'hE0, "masked irq");
        tx_fail <= 1'h0;
        wr(IDX_CMD, 32'h1);
        wr(IDX_CTL, 32'h1);
        @(posedge pclk);
        chk({31'h0, tx_abort}, 32'h1, "reset abort");
        chk({31'h0, reset_mode}, 32'h1, "reset mode");
        wr(IDX_CTL, 32'h2);
        chk_st();
        push();
        push();
        chk_st();
        rd(IDX_INT);
        chk(rdv, 32'hE1, "rx irq");
        rel();
        chk_st();
        rd(IDX_INT);
        chk(rdv, 32'hE1, "rx irq again");
        rel();
        chk_st();
        wr(IDX_CTL, 32'h10);
        for (i = 0; i < 5; i++) push();
        chk_st();
        rd(IDX_INT);
        chk(rdv, 32'hE8, "overrun irq");
        wr(IDX_CMD, 32'h10);
        chk_st();
        wr(IDX_CMD, 32'h8);
        overrun_flag = 1'h0;
        chk_st();
        for (i = 0; i < 4; i++) rel();
        chk_st();
        wr(IDX_CTL, 32'h0);
        for (i = 0; i < 8; i++) begin
            @(posedge pclk);
            tx_err_cnt <= 8'h5E + 8'($urandom_range(4));
            rx_err_cnt <= 8'h5E + 8'($urandom_range(4));
            bus_off <= 1'($urandom_range(1));
            rx_active <= 1'($urandom_range(1));
            chk_st();
            rd(IDX_ERR);
            chk(rdv, {16'h0, rx_err_cnt, tx_err_cnt}, "counters");
        end
        stop_test();
    end
endmodule : tb_top
`default_nettype wire
